/* src/dbsc_control.sv */
// converter control: synchronised access, two-stage sample queue, events, routing and pump
// Operation
// - synchronised access raises pending at once, clears when synchronisation finishes
// - access arriving while pending is dropped without effect and flags an error
// - soft reset, enable, output sample and staging writes are synchronised
// - output sample reads are synchronised before data returns
// - internal route feeds comparator input, allowed together with external output
// - staging and output sample registers form a two-entry queue
// - enabled start event moves staged sample out, or drops it when an output sample write completes in that cycle, and starts a conversion
// - start event with empty staging raises underrun request when enabled
// - staging emptying emits buffer-empty event when its output enable is set
// - staging emptying raises buffer-empty request when that request is enabled
// - pump turns on automatically when supply is below 2.5V while the converter is enabled
// - pump disable bit turns pump off; advised only above 2.5V
`timescale 1ns/1ns
module dbsc_control (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        clkEn,
  // access requests
  input  wire dbsc_pkg::dbsc_req_s         req,
  output logic                             syncPending,
  output logic                             syncError,
  output logic                             rdValid,
  output logic [dbsc_pkg::SAMPLE_W-1:0]    rdData,
  // configuration
  input  wire dbsc_pkg::dbsc_cfg_s         cfg,
  // event and supply inputs
  input  wire logic                        startEventPin,
  input  wire logic                        lowSupplyPin,
  // converter side
  output logic                             convEnabled,
  output logic [dbsc_pkg::SAMPLE_W-1:0]    convSample,
  output logic                             convStart,
  output logic                             toComparator,
  output logic                             toPin,
  output logic                             pumpOn,
  // events and requests
  output logic                             emptyEvent,
  output logic                             emptyIrq,
  output logic                             underrunIrq,
  output logic                             stageFull,
  output logic                             softResetActive
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  dbsc_pkg::dbsc_state_e            state;
  dbsc_pkg::dbsc_op_e               pendOp;
  logic [dbsc_pkg::SAMPLE_W-1:0]    pendData;
  logic [2:0]                       cnt;
  logic [dbsc_pkg::SAMPLE_W-1:0]    stage;
  logic                             startRise;
  logic                             lowSupply;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  dbsc_pin_sync u_start_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .pinIn   (startEventPin),
    .level   (),
    .rise    (startRise)
  );

  dbsc_pin_sync u_supply_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .pinIn   (lowSupplyPin),
    .level   (lowSupply),
    .rise    ()
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic accept;
  logic reject;
  logic done;
  logic doneReset;
  logic doneEnable;
  logic doneOut;
  logic doneStage;
  logic doneRead;
  logic startEv;
  logic eventLoad;
  logic eventUnder;

  // access handshake against pending flag
  assign accept     = clkEn & req.valid & (state == dbsc_pkg::ST_IDLE);
  assign reject     = clkEn & req.valid & (state == dbsc_pkg::ST_SYNC);
  assign done       = clkEn & (state == dbsc_pkg::ST_SYNC) & (cnt == dbsc_pkg::CNT_LAST);
  assign doneReset  = done & (pendOp == dbsc_pkg::OP_SOFT_RESET);
  assign doneEnable = done & (pendOp == dbsc_pkg::OP_ENABLE);
  assign doneOut    = done & (pendOp == dbsc_pkg::OP_OUT_SAMPLE);
  assign doneStage  = done & (pendOp == dbsc_pkg::OP_STAGE);
  assign doneRead   = done & (pendOp == dbsc_pkg::OP_READ);

  // start events and queue outcome
  assign startEv    = clkEn & startRise & cfg.startEventInputEn & convEnabled & ~doneReset;
  assign eventLoad  = startEv & stageFull;
  assign eventUnder = startEv & ~stageFull;

  // ----------------------------------------
  // synchronisation sequencer
  // ----------------------------------------
  dbsc_pkg::dbsc_state_e next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      dbsc_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = dbsc_pkg::ST_SYNC;
        end
      end
      dbsc_pkg::ST_SYNC: begin
        if (done) begin
          next_state = dbsc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dbsc_pkg::ST_IDLE;
      end
    endcase
  end

  // state, captured operation and latency count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= dbsc_pkg::ST_IDLE;
      pendOp   <= dbsc_pkg::OP_READ;
      pendData <= dbsc_pkg::SAMPLE_RST;
      cnt      <= 3'h0;
    end else if (clkEn) begin
      state <= next_state;
      if (accept) begin
        pendOp   <= req.op;
        pendData <= req.data;
        cnt      <= dbsc_pkg::SYNC_CYCLES;
      end else if (state == dbsc_pkg::ST_SYNC) begin
        cnt <= cnt - 3'h1;
      end
    end
  end

  // pending and error flags
  assign syncPending     = (state == dbsc_pkg::ST_SYNC);
  assign softResetActive = syncPending & (pendOp == dbsc_pkg::OP_SOFT_RESET);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncError <= dbsc_pkg::FLAG_RST;
      rdValid   <= dbsc_pkg::FLAG_RST;
      rdData    <= dbsc_pkg::SAMPLE_RST;
    end else if (clkEn) begin
      syncError <= reject;
      rdValid   <= doneRead;
      if (doneRead) begin
        rdData <= convSample;
      end
    end
  end

  // ----------------------------------------
  // sample queue and converter control
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      convEnabled <= dbsc_pkg::FLAG_RST;
      convSample  <= dbsc_pkg::SAMPLE_RST;
      stage       <= dbsc_pkg::SAMPLE_RST;
      stageFull   <= dbsc_pkg::FLAG_RST;
    end else if (clkEn) begin
      if (doneReset) begin
        convEnabled <= dbsc_pkg::FLAG_RST;
        convSample  <= dbsc_pkg::SAMPLE_RST;
        stage       <= dbsc_pkg::SAMPLE_RST;
        stageFull   <= dbsc_pkg::FLAG_RST;
      end else begin
        if (doneEnable) begin
          convEnabled <= pendData[0];
        end
        if (doneOut) begin
          convSample <= pendData;
        end else if (eventLoad) begin
          convSample <= stage;
        end
        if (doneStage) begin
          stage     <= pendData;
          stageFull <= 1'h1;
        end else if (eventLoad) begin
          stageFull <= 1'h0;
        end
      end
    end
  end

  // event and request pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      convStart   <= dbsc_pkg::FLAG_RST;
      emptyEvent  <= dbsc_pkg::FLAG_RST;
      emptyIrq    <= dbsc_pkg::FLAG_RST;
      underrunIrq <= dbsc_pkg::FLAG_RST;
    end else if (clkEn) begin
      convStart   <= startEv;
      emptyEvent  <= eventLoad & ~doneStage & cfg.emptyEventOutputEn;
      emptyIrq    <= eventLoad & ~doneStage & cfg.emptyIntEn;
      underrunIrq <= eventUnder & cfg.underrunIntEn;
    end
  end

  // output routing and pump
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      toComparator <= dbsc_pkg::FLAG_RST;
      toPin        <= dbsc_pkg::FLAG_RST;
      pumpOn       <= dbsc_pkg::FLAG_RST;
    end else if (clkEn) begin
      toComparator <= convEnabled & cfg.internalOutputRouteEn;
      toPin        <= convEnabled & cfg.externalOutputEn;
      pumpOn       <= convEnabled & lowSupply & ~cfg.pumpDisable;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_accept_read;
    accept && (req.op == dbsc_pkg::OP_READ);
  endsequence

  sequence s_sync_wait;
    clkEn[*4];
  endsequence

  a_pending_set: assert property (@(posedge sys_clk) disable iff (!rst_n) accept |=> syncPending)
    else $error("pending flag not raised after access");

  a_pending_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept ##1 s_sync_wait |=> !syncPending)
    else $error("pending flag not cleared after synchronisation");

  a_drop_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reject |=> syncError && (pendOp == $past(pendOp)) && (pendData == $past(pendData)))
    else $error("colliding access not dropped with error");

  a_stage_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept && (req.op == dbsc_pkg::OP_STAGE) && !stageFull |=> !stageFull)
    else $error("staging write took effect before synchronisation");

  a_read_return: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_accept_read ##1 s_sync_wait |=> rdValid && (rdData == $past(convSample)))
    else $error("synchronised read did not return the output sample");

  a_route_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && convEnabled && cfg.internalOutputRouteEn && cfg.externalOutputEn |=> toComparator && toPin)
    else $error("internal and external outputs not enabled together");

  a_queue_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eventLoad && !doneOut |=> convStart && (convSample == $past(stage)))
    else $error("start event did not move the staged sample");

  a_underrun_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eventUnder |=> (underrunIrq == $past(cfg.underrunIntEn)) && !emptyEvent)
    else $error("underrun request wrong");

  a_empty_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eventLoad && !doneStage |=> (emptyEvent == $past(cfg.emptyEventOutputEn)) && !stageFull)
    else $error("buffer-empty event wrong");

  a_empty_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && !eventLoad |=> !emptyIrq)
    else $error("buffer-empty request without the staging emptying");

  a_pump_auto: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && convEnabled && lowSupply && !cfg.pumpDisable |=> pumpOn)
    else $error("pump not on at low supply");

  a_pump_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && cfg.pumpDisable |=> !pumpOn)
    else $error("pump on while disabled");

  a_underrun_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eventUnder && !doneOut |=> convStart && $stable(convSample))
    else $error("underrun changed the held sample");

endmodule : dbsc_control

/* src/dbsc_pin_sync.sv */
// three-stage input synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module dbsc_pin_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  // asynchronous input
  input  wire logic pinIn,
  // synchronised outputs
  output logic      level,
  output logic      rise
);

  logic s1;
  logic s2;
  logic s3;
  logic agree;

  // ----------------------------------------
  // agreement of the last two stages
  // ----------------------------------------
  assign agree = (s2 == s3);

  // shift chain, first stage read only by the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end else if (clkEn) begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // filtered level and one-cycle rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'h0;
      rise  <= 1'h0;
    end else if (clkEn) begin
      level <= agree ? s3 : level;
      rise  <= agree & s3 & ~level;
    end
  end

endmodule : dbsc_pin_sync

/* src/dbsc_pkg.sv */
// shared constants and types for the converter buffer and synchronisation control
package dbsc_pkg;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int         SAMPLE_W    = 10;
  localparam logic [2:0] SYNC_CYCLES = 3'h4;   // cycles a synchronised access stays pending
  localparam logic [2:0] CNT_LAST    = 3'h1;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 10'h000;
  localparam logic                FLAG_RST   = 1'h0;

  // ----------------------------------------
  // operations that need synchronisation
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_SOFT_RESET = 5'h01,
    OP_ENABLE     = 5'h02,
    OP_OUT_SAMPLE = 5'h04,
    OP_STAGE      = 5'h08,
    OP_READ       = 5'h10
  } dbsc_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_SYNC = 2'h2
  } dbsc_state_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic                valid;
    dbsc_op_e            op;
    logic [SAMPLE_W-1:0] data;
  } dbsc_req_s;

  typedef struct packed {
    logic internalOutputRouteEn;
    logic externalOutputEn;
    logic startEventInputEn;
    logic emptyEventOutputEn;
    logic underrunIntEn;
    logic emptyIntEn;
    logic pumpDisable;
  } dbsc_cfg_s;

endpackage : dbsc_pkg

/* tb/dbsc_control_bench.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ns
module dbsc_control_bench;
  logic                          sys_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          clkEn = 1'b1;
  dbsc_pkg::dbsc_req_s           req = '0;
  dbsc_pkg::dbsc_cfg_s           cfg = '0;
  logic                          lowSupplyPin = 1'b0;
  logic                          fire = 1'b0;
  logic                          startEventPin, syncPending, syncError, rdValid, convEnabled, convStart;
  logic                          toComparator, toPin, pumpOn, emptyEvent, emptyIrq, underrunIrq, stageFull;
  logic                          softResetActive;
  logic [dbsc_pkg::SAMPLE_W-1:0] rdData, convSample;
  int                            convCount;
  int                            errors = 0;
  int                            n_tests = 0;
  int                            cycles = 0;
  bit                            seen;

  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  always #5 sys_clk = ~sys_clk;

  dbsc_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .req(req), .syncPending(syncPending),
    .syncError(syncError), .rdValid(rdValid), .rdData(rdData), .cfg(cfg), .startEventPin(startEventPin),
    .lowSupplyPin(lowSupplyPin), .convEnabled(convEnabled), .convSample(convSample), .convStart(convStart),
    .toComparator(toComparator), .toPin(toPin), .pumpOn(pumpOn), .emptyEvent(emptyEvent), .emptyIrq(emptyIrq),
    .underrunIrq(underrunIrq), .stageFull(stageFull), .softResetActive(softResetActive));

  dbsc_partner far (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire), .convStart(convStart),
    .startEventPin(startEventPin), .convCount(convCount));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task step;
    @(posedge sys_clk);
    #1;
  endtask : step

  task chk(input string name, input int exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp[9:0]) begin
      $display("unexpected %s expected %h seen %h", name, exp[9:0], got);
      errors++;
    end
  endtask : chk

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // one synchronised access, optionally followed by a colliding request
  task access(input dbsc_pkg::dbsc_op_e op, input logic [9:0] data, input bit collide);
    req.valid = 1'b1;
    req.op    = op;
    req.data  = data;
    step;
    req.valid = collide;
    req.data  = ~data;
    for (int i = 1; i <= 4; i++) begin
      chk("syncPending", 1, syncPending);
      chk("softResetActive", op == dbsc_pkg::OP_SOFT_RESET, softResetActive);
      if (i == 2)
        chk("syncError", collide, syncError);
      step;
      // drop the colliding request once; a back-to-back access may raise it again
      if (i == 1)
        req.valid = 1'b0;
    end
    chk("syncPending done", 0, syncPending);
  endtask : access

  // pulse the event source and stop in the cycle of convStart
  task fire_event;
    // let the event source and the pin synchroniser fall idle first
    repeat (10) step;
    fire = 1'b1;
    step;
    fire = 1'b0;
    seen = 1'b0;
    repeat (12) begin
      if (!seen) begin
        if (convStart === 1'b1)
          seen = 1'b1;
        else
          step;
      end
    end
  endtask : fire_event

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task sc_access;
    access(dbsc_pkg::OP_ENABLE, 10'h001, 1'b0);
    chk("convEnabled", 1, convEnabled);
    access(dbsc_pkg::OP_OUT_SAMPLE, 10'h155, 1'b0);
    chk("convSample", 10'h155, convSample);
    access(dbsc_pkg::OP_READ, 10'h000, 1'b0);
    chk("rdValid", 1, rdValid);
    chk("rdData", 10'h155, rdData);
  endtask : sc_access

  task sc_route;
    cfg.internalOutputRouteEn = 1'b1;
    cfg.externalOutputEn      = 1'b1;
    step;
    step;
    chk("toComparator", 1, toComparator);
    chk("toPin", 1, toPin);
    cfg.internalOutputRouteEn = 1'b0;
    step;
    step;
    chk("toComparator off", 0, toComparator);
  endtask : sc_route

  task sc_queue;
    access(dbsc_pkg::OP_STAGE, 10'h2AA, 1'b1);
    chk("stageFull", 1, stageFull);
    chk("convSample held", 10'h155, convSample);
    fire_event;
    chk("refused event", 0, seen);
    cfg.startEventInputEn  = 1'b1;
    cfg.emptyEventOutputEn = 1'b1;
    cfg.emptyIntEn         = 1'b1;
    cfg.underrunIntEn      = 1'b1;
    fire_event;
    chk("convStart", 1, seen);
    chk("convSample load", 10'h2AA, convSample);
    chk("stageFull empty", 0, stageFull);
    chk("emptyEvent", 1, emptyEvent);
    chk("emptyIrq", 1, emptyIrq);
    chk("underrunIrq", 0, underrunIrq);
    fire_event;
    chk("underrun start", 1, seen);
    chk("underrunIrq", 1, underrunIrq);
    chk("convSample kept", 10'h2AA, convSample);
    chk("emptyEvent", 0, emptyEvent);
    step;
    chk("convCount", 2, convCount[9:0]);
  endtask : sc_queue

  task sc_pump;
    lowSupplyPin = 1'b1;
    repeat (8) step;
    chk("pumpOn", 1, pumpOn);
    cfg.pumpDisable = 1'b1;
    step;
    step;
    chk("pumpOn disabled", 0, pumpOn);
  endtask : sc_pump

  task sc_soft_reset;
    access(dbsc_pkg::OP_SOFT_RESET, 10'h000, 1'b0);
    chk("convEnabled", 0, convEnabled);
    chk("convSample", 10'h000, convSample);
  endtask : sc_soft_reset

  // ----------------------------------------
  // main sequence and timeout
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    chk("syncPending in reset", 0, syncPending);
    chk("convSample in reset", 10'h000, convSample);
    #1 rst_n = 1'b1;
    step;
    sc_access;
    sc_route;
    sc_queue;
    sc_pump;
    sc_soft_reset;
    report_and_stop;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop;
    end
  end
endmodule : dbsc_control_bench

/* tb/dbsc_partner.sv */
// event source and converter core model for the converter control bench
`timescale 1ns/1ns
module dbsc_partner (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // bench command
  input  wire logic fire,
  // converter side
  input  wire logic convStart,
  output logic      startEventPin,
  output int        convCount
);
  logic [3:0] holdCnt;

  // ----------------------------------------
  // start event pulse and conversion count
  // ----------------------------------------
  // each event holds high 4 cycles, low at least 4, well below the converter clock rate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt       <= 4'h0;
      startEventPin <= 1'b0;
      convCount     <= 0;
    end else begin
      if (fire && holdCnt == 4'h0)
        holdCnt <= 4'h8;
      else if (holdCnt != 4'h0)
        holdCnt <= holdCnt - 4'h1;
      startEventPin <= (holdCnt > 4'h4);
      if (convStart)
        convCount <= convCount + 1;
    end
  end
endmodule : dbsc_partner
